// ==== hdl/lpm_clock_ctrl.sv ====
`timescale 1ns/1ps
`include "lpm_map.svh"

module lpm_clock_ctrl #(
  parameter int AW        = 20,
  parameter int DW        = 16,
  parameter int PW        = 8,
  parameter int SETTLE_NS = `LPM_SETTLE_NS
) (
  input  wire logic               CLK,
  input  wire logic               RSTN,
  input  wire logic               CE,
  input  wire logic               CTRL_WE,
  input  wire logic               WR_ALL_CLOCK_HALT_BIT,
  input  wire logic               WR_FORCE_DIV8_SELECT,
  input  wire logic               WR_MAIN_OSC_DRIVE_STRENGTH,
  input  wire logic               WR_WAIT_PERIPH_CLOCK_GATE_BIT,
  input  wire logic               WR_DIVIDER_FIELD_LOW,
  input  wire logic               WR_DIVIDER_FIELD_HIGH,
  input  wire logic               WR_MAIN_OSC_STOP_BIT,
  input  wire logic               WR_SYSTEM_CLOCK_SOURCE_SELECT,
  input  wire logic [1:0]         WR_CLOCK_OUTPUT_SELECT,
  input  wire logic               WAIT_EXEC,
  input  wire logic               IRQ_ACCEPT,
  input  wire logic               SUB_OSC_INPUT,
  input  wire logic               TIMER_EXT_PULSE,
  input  wire logic               SERIAL_EXT_CLOCK,
  input  wire logic               TIMER_EXT_MODE,
  input  wire logic               SERIAL_EXT_SELECT,
  input  wire logic               BUS_EXPANSION_MODE,
  input  wire logic [AW-1:0]      ADDR_IN,
  input  wire logic [DW-1:0]      DATA_IN,
  input  wire logic [3:0]         CHIP_SELECT_LINE_N_IN,
  input  wire logic               BYTE_HIGH_ENABLE_N_IN,
  input  wire logic [3:0]         STROBE_N_IN,
  input  wire logic               HOLD_ACKNOWLEDGE_N_IN,
  input  wire logic               ADDR_LATCH_IN,
  input  wire logic [PW-1:0]      PORT_IN,
  output logic                    ALL_CLOCK_HALT_BIT,
  output logic                    FORCE_DIV8_SELECT,
  output logic                    MAIN_OSC_DRIVE_STRENGTH,
  output logic                    WAIT_PERIPH_CLOCK_GATE_BIT,
  output logic                    DIVIDER_FIELD_LOW,
  output logic                    DIVIDER_FIELD_HIGH,
  output logic                    MAIN_OSC_STOP_BIT,
  output logic                    SYSTEM_CLOCK_SOURCE_SELECT,
  output logic [1:0]              CLOCK_OUTPUT_SELECT,
  output lpm_pkg::lpm_state_e     POWER_STATE,
  output logic                    MAIN_OSC_EN,
  output logic                    SUB_OSC_EN,
  output logic                    BCLK_EN,
  output logic                    WDT_CLK_EN,
  output logic                    PERIPH_F1_EN,
  output logic                    PERIPH_F8_EN,
  output logic                    PERIPH_F32_EN,
  output logic                    SERIAL_AUX_CLOCK_EN,
  output logic                    CONVERTER_CLOCK_EN,
  output logic                    SUBCLOCK_DIRECT_EN,
  output logic                    SUBCLOCK_DIV32_EN,
  output logic                    TIMER_COUNT_EXT_EN,
  output logic                    SERIAL_EXT_CLK_EN,
  output logic                    HANDLER_START,
  output logic [AW-1:0]           ADDR_OUT,
  output logic [DW-1:0]           DATA_OUT,
  output logic [3:0]              CHIP_SELECT_LINE_N_OUT,
  output logic                    BYTE_HIGH_ENABLE_N_OUT,
  output logic [3:0]              STROBE_N_OUT,
  output logic                    HOLD_ACKNOWLEDGE_N_OUT,
  output logic                    ADDR_LATCH_OUT,
  output logic                    BUS_CLOCK_OUT,
  output logic [PW-1:0]           PORT_OUT,
  output logic                    CLOCK_OUTPUT_PIN
);
  import lpm_pkg::*;

  // Restart wait in cycles, rounded up, never below one
  localparam int SETTLE_RAW   = (SETTLE_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
  localparam int SETTLE_CYC   = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int SETTLE_BOUND = SETTLE_CYC + 3;
  localparam logic [15:0] SETTLE_LD = 16'(SETTLE_CYC);

  typedef struct packed {
    lpm_state_e    st;
    logic          div8;
    logic          drv;
    logic          gate;
    logic          mstop;
    logic          src;
    logic          halt;
    logic          bsrc;
    logic          hand;
    logic          busclk;
    logic          ck;
    logic          f8;
    logic          f32;
    logic          fc32t;
    logic [1:0]    divf;
    logic [1:0]    cksel;
    logic [15:0]   settle;
    logic [4:0]    pcnt;
    logic [4:0]    scnt;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [3:0]    cs_n;
    logic          bhe_n;
    logic [3:0]    stb_n;
    logic          hold_acknowledge_n;
    logic          ale;
    logic [PW-1:0] port;
  } lpm_ctl_s;

  lpm_ctl_s   q;
  lpm_ctl_s   n;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic       sub_rise;
  logic       div_tick;
  logic       running;
  logic       lowp;
  logic       main_run;
  logic       periph_run;
  logic       div_run;
  logic       bclk_en;

  // Pins from outside the clock domain: sub oscillator, timer pulse, serial clock
  lpm_sync #(.W(3)) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .d     ({SERIAL_EXT_CLOCK, TIMER_EXT_PULSE, SUB_OSC_INPUT}),
    .level (pin_lvl),
    .rise  (pin_rise)
  );

  lpm_div u_div (
    .clk   (CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .run   (div_run),
    .ratio (lpm_ratio(q.div8, q.divf)),
    .tick  (div_tick)
  );

  // Clock gating terms; settle counts as stop so nothing runs on a cold oscillator
  assign sub_rise   = pin_rise[0];
  assign running    = (q.st == LPM_RUN);
  assign lowp       = (q.st == LPM_STOP) || (q.st == LPM_SETTLE);
  assign main_run   = !lowp && !q.mstop;
  assign periph_run = main_run && !((q.st == LPM_WAIT) && q.gate);
  assign div_run    = main_run && running && !q.bsrc;
  assign bclk_en    = running && (q.bsrc ? sub_rise : div_tick);

  always_comb begin
    n = q;
    // Pulses last one cycle; with CE low they freeze like all other state
    if (CE) begin
      n.hand  = 1'b0;
      n.f8    = 1'b0;
      n.f32   = 1'b0;
      n.fc32t = 1'b0;
      // Power state sequencing; the CPU only writes or waits while running
      unique case (q.st)
        LPM_RUN: begin
          if (CTRL_WE) begin
            n.div8  = WR_FORCE_DIV8_SELECT;
            n.drv   = WR_MAIN_OSC_DRIVE_STRENGTH;
            n.gate  = WR_WAIT_PERIPH_CLOCK_GATE_BIT;
            n.divf  = {WR_DIVIDER_FIELD_HIGH, WR_DIVIDER_FIELD_LOW};
            n.mstop = WR_MAIN_OSC_STOP_BIT;
            n.src   = WR_SYSTEM_CLOCK_SOURCE_SELECT;
            n.cksel = WR_CLOCK_OUTPUT_SELECT;
            // Main stop with the sub clock already selected is low power entry
            if (WR_MAIN_OSC_STOP_BIT && !q.mstop && q.src && WR_SYSTEM_CLOCK_SOURCE_SELECT) begin
              n.div8 = 1'b1;
              n.drv  = 1'b1;
            end
            if (WR_ALL_CLOCK_HALT_BIT) begin
              n.st   = LPM_STOP;
              n.halt = 1'b1;
              if (!q.bsrc) begin
                n.div8 = 1'b1;
                n.drv  = 1'b1;
              end
            end
          end else if (WAIT_EXEC) begin
            n.st = LPM_WAIT;
          end
        end
        LPM_WAIT: begin
          // Source registers are untouched, so the old bus clock resumes
          if (IRQ_ACCEPT) begin
            n.st   = LPM_RUN;
            n.hand = 1'b1;
          end
        end
        LPM_STOP: begin
          // Nothing but an accepted interrupt leaves stop; reset acts asynchronously
          if (IRQ_ACCEPT) begin
            n.st     = LPM_SETTLE;
            n.settle = SETTLE_LD;
          end
        end
        LPM_SETTLE: begin
          if (q.settle <= 16'h0001) begin
            n.st   = LPM_RUN;
            n.hand = 1'b1;
            n.halt = 1'b0;
          end else begin
            n.settle = q.settle - 16'h0001;
          end
        end
      endcase

      // Source change lands on a pulse of the old source, or at once from the main clock if main stop is set
      if (q.src != q.bsrc && (q.bsrc ? sub_rise : (div_tick || q.mstop))) begin
        n.bsrc = q.src;
      end

      // Peripheral prescaler runs off the main clock
      if (periph_run) begin
        n.pcnt = q.pcnt + 5'h01;
        n.f8   = (q.pcnt[2:0] == 3'h7);
        n.f32  = (q.pcnt == 5'h1F);
      end

      // Sub clock over 32 keeps going in wait but not in stop
      if (!lowp && sub_rise) begin
        n.scnt  = q.scnt + 5'h01;
        n.fc32t = (q.scnt == 5'h1F);
      end

      // Bus pins follow the CPU while running and freeze or park high otherwise
      if (running) begin
        n.addr   = ADDR_IN;
        n.data   = DATA_IN;
        n.cs_n   = CHIP_SELECT_LINE_N_IN;
        n.bhe_n  = BYTE_HIGH_ENABLE_N_IN;
        n.stb_n  = STROBE_N_IN;
        n.hold_acknowledge_n = HOLD_ACKNOWLEDGE_N_IN;
        n.ale    = ADDR_LATCH_IN;
        n.port   = PORT_IN;
        n.busclk = bclk_en ? ~q.busclk : q.busclk;
      end else if (BUS_EXPANSION_MODE) begin
        n.stb_n  = 4'hF;
        n.hold_acknowledge_n = 1'b1;
        n.ale    = 1'b1;
        n.busclk = 1'b1;
      end

      // Clock output pin, single-chip mode only
      if (!BUS_EXPANSION_MODE) begin
        unique case (q.cksel)
          `LPM_CKSEL_FC:   n.ck = lowp ? 1'b1 : pin_lvl[0];
          `LPM_CKSEL_F8:   n.ck = q.f8 ? ~q.ck : q.ck;
          `LPM_CKSEL_F32:  n.ck = q.f32 ? ~q.ck : q.ck;
          `LPM_CKSEL_PORT: n.ck = q.ck;
        endcase
      end
    end
  end

  // Control bits take their reset values here, divide-by-8 among them
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q       <= '0;
      q.st    <= LPM_RUN;
      q.div8  <= `LPM_RST_DIV8;
      q.drv   <= `LPM_RST_DRIVE;
      q.gate  <= `LPM_RST_GATE;
      q.divf  <= `LPM_RST_DIVF;
      q.mstop <= `LPM_RST_MSTOP;
      q.src   <= `LPM_RST_SRC;
      q.bsrc  <= `LPM_RST_SRC;
      q.halt  <= `LPM_RST_HALT;
      q.cksel <= `LPM_RST_CKSEL;
      q.stb_n <= 4'hF;
      q.cs_n  <= 4'hF;
      q.bhe_n <= 1'b1;
      q.hold_acknowledge_n <= 1'b1;
      q.busclk <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Status and clock enables
  assign ALL_CLOCK_HALT_BIT         = q.halt;
  assign FORCE_DIV8_SELECT          = q.div8;
  assign MAIN_OSC_DRIVE_STRENGTH    = q.drv;
  assign WAIT_PERIPH_CLOCK_GATE_BIT = q.gate;
  assign DIVIDER_FIELD_LOW          = q.divf[0];
  assign DIVIDER_FIELD_HIGH         = q.divf[1];
  assign MAIN_OSC_STOP_BIT          = q.mstop;
  assign SYSTEM_CLOCK_SOURCE_SELECT = q.src;
  assign CLOCK_OUTPUT_SELECT        = q.cksel;
  assign POWER_STATE                = q.st;
  assign MAIN_OSC_EN                = (q.st != LPM_STOP) && !q.mstop;
  assign SUB_OSC_EN                 = (q.st != LPM_STOP);
  assign BCLK_EN                    = bclk_en;
  assign WDT_CLK_EN                 = bclk_en;
  assign PERIPH_F1_EN               = periph_run;
  assign PERIPH_F8_EN               = q.f8;
  assign PERIPH_F32_EN              = q.f32;
  assign SERIAL_AUX_CLOCK_EN        = periph_run;
  assign CONVERTER_CLOCK_EN         = periph_run;
  assign SUBCLOCK_DIRECT_EN         = !lowp && sub_rise;
  assign SUBCLOCK_DIV32_EN          = q.fc32t;
  // External clocks bypass all gating so counters keep running in stop
  assign TIMER_COUNT_EXT_EN         = TIMER_EXT_MODE && pin_rise[1];
  assign SERIAL_EXT_CLK_EN          = SERIAL_EXT_SELECT && pin_rise[2];
  assign HANDLER_START              = q.hand;
  assign ADDR_OUT                   = q.addr;
  assign DATA_OUT                   = q.data;
  assign CHIP_SELECT_LINE_N_OUT     = q.cs_n;
  assign BYTE_HIGH_ENABLE_N_OUT     = q.bhe_n;
  assign STROBE_N_OUT               = q.stb_n;
  assign HOLD_ACKNOWLEDGE_N_OUT     = q.hold_acknowledge_n;
  assign ADDR_LATCH_OUT             = q.ale;
  assign BUS_CLOCK_OUT              = q.busclk;
  assign PORT_OUT                   = q.port;
  assign CLOCK_OUTPUT_PIN           = q.ck;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN || !CE);

  stop_entry_a: assert property (
    (running && CTRL_WE && WR_ALL_CLOCK_HALT_BIT) |=> (q.st == LPM_STOP) && !MAIN_OSC_EN && !SUB_OSC_EN)
    else $error("halt write did not stop oscillators");
  stop_clocks_a: assert property (
    (q.st == LPM_STOP) |-> !BCLK_EN && !CONVERTER_CLOCK_EN && !WDT_CLK_EN && !SUBCLOCK_DIRECT_EN)
    else $error("clock running in stop");
  ext_event_a: assert property (
    (TIMER_EXT_MODE && pin_lvl[1] && !$past(pin_lvl[1])) |-> TIMER_COUNT_EXT_EN)
    else $error("external event lost");
  stop_hold_a: assert property (
    ((q.st == LPM_STOP) && !IRQ_ACCEPT) |=> (q.st == LPM_STOP))
    else $error("stop left without interrupt");
  stop_wake_a: assert property (
    ((q.st == LPM_STOP) && IRQ_ACCEPT) |=>
    (!BCLK_EN throughout ##[0:SETTLE_BOUND] ((q.st == LPM_SETTLE) && (q.settle <= 16'h0001)))
    ##1 HANDLER_START)
    else $error("stop wake did not reach handler");
  force_bits_a: assert property (
    (running && CTRL_WE && WR_ALL_CLOCK_HALT_BIT && !q.bsrc) |=> FORCE_DIV8_SELECT && MAIN_OSC_DRIVE_STRENGTH)
    else $error("stop entry did not force bits");
  lowspeed_keep_a: assert property (
    (running && CTRL_WE && WR_SYSTEM_CLOCK_SOURCE_SELECT && !q.src && !WR_ALL_CLOCK_HALT_BIT)
    |=> FORCE_DIV8_SELECT == $past(WR_FORCE_DIV8_SELECT))
    else $error("low-speed entry changed divide select");
  bus_high_a: assert property (
    (!running && BUS_EXPANSION_MODE) |=> (&STROBE_N_OUT) && HOLD_ACKNOWLEDGE_N_OUT && ADDR_LATCH_OUT && BUS_CLOCK_OUT)
    else $error("bus strobes not parked high");
  addr_hold_a: assert property (
    (!running && !$past(running)) |-> $stable(ADDR_OUT) && $stable(PORT_OUT))
    else $error("address moved in low power");
  clock_output_pin_stop_a: assert property (
    ((q.st == LPM_STOP) && !BUS_EXPANSION_MODE && (q.cksel == `LPM_CKSEL_FC)) |=> CLOCK_OUTPUT_PIN)
    else $error("clock pin not high in stop");
  wait_entry_a: assert property (
    (running && WAIT_EXEC && !CTRL_WE) |=> (q.st == LPM_WAIT) && !BCLK_EN && !WDT_CLK_EN)
    else $error("wait did not stop bus clock");
  wait_gate_a: assert property (
    ((q.st == LPM_WAIT) && $past(q.st == LPM_WAIT) && q.gate) |-> !PERIPH_F1_EN && !PERIPH_F8_EN)
    else $error("peripheral clock ran in gated wait");
  wait_wake_a: assert property (
    ((q.st == LPM_WAIT) && IRQ_ACCEPT) |=> running && HANDLER_START && $stable(q.bsrc))
    else $error("wait wake wrong");
  lowpower_a: assert property (
    (running && CTRL_WE && WR_MAIN_OSC_STOP_BIT && q.src && WR_SYSTEM_CLOCK_SOURCE_SELECT)
    |=> !MAIN_OSC_EN && FORCE_DIV8_SELECT)
    else $error("low power entry wrong");

  wait_wake_c:  cover property ((q.st == LPM_WAIT) ##1 HANDLER_START);
  stop_wake_c:  cover property ((q.st == LPM_SETTLE) ##1 HANDLER_START);
  lowpower_c:   cover property (running && q.mstop && q.bsrc && BCLK_EN);
  ext_stop_c:   cover property ((q.st == LPM_STOP) && TIMER_COUNT_EXT_EN);

endmodule : lpm_clock_ctrl

// ==== inc/lpm_map.svh ====
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

// Clock rate and oscillator restart time after stop
`define LPM_CLK_PERIOD_NS 4
`define LPM_SETTLE_NS     1000

// Reset values of the control bits
`define LPM_RST_DIV8  1'b1
`define LPM_RST_DRIVE 1'b1
`define LPM_RST_GATE  1'b0
`define LPM_RST_DIVF  2'b00
`define LPM_RST_MSTOP 1'b0
`define LPM_RST_SRC   1'b0
`define LPM_RST_HALT  1'b0
`define LPM_RST_CKSEL 2'b00

// Divider field codes and the ratios they give
`define LPM_DIVF_NONE 2'b00
`define LPM_DIVF_BY2  2'b01
`define LPM_DIVF_BY4  2'b10
`define LPM_DIVF_BY16 2'b11
`define LPM_RATIO_1   5'h01
`define LPM_RATIO_2   5'h02
`define LPM_RATIO_4   5'h04
`define LPM_RATIO_8   5'h08
`define LPM_RATIO_16  5'h10

// Clock output source codes
`define LPM_CKSEL_PORT 2'b00
`define LPM_CKSEL_FC   2'b01
`define LPM_CKSEL_F8   2'b10
`define LPM_CKSEL_F32  2'b11

`endif

// ==== inc/lpm_pkg.sv ====
`include "lpm_map.svh"

package lpm_pkg;

  // Power state of the clock controller
  typedef enum logic [1:0] {LPM_RUN, LPM_WAIT, LPM_STOP, LPM_SETTLE} lpm_state_e;

  typedef logic [4:0] lpm_ratio_t;

  // Bus clock divide ratio from the divide-by-8 select and the divider field
  function automatic lpm_ratio_t lpm_ratio(input logic div8, input logic [1:0] divf);
    lpm_ratio_t r;
    r = `LPM_RATIO_8;
    if (!div8) begin
      unique case (divf)
        `LPM_DIVF_NONE: r = `LPM_RATIO_1;
        `LPM_DIVF_BY2:  r = `LPM_RATIO_2;
        `LPM_DIVF_BY4:  r = `LPM_RATIO_4;
        `LPM_DIVF_BY16: r = `LPM_RATIO_16;
      endcase
    end
    return r;
  endfunction : lpm_ratio

endpackage : lpm_pkg

// ==== hdl/lpm_sync.sv ====
`timescale 1ns/1ps

module lpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } lpm_sync_s;

  lpm_sync_s q;
  lpm_sync_s n;

  // Two stages for metastability, a third only for the edge
  always_comb begin
    n = q;
    if (ce) begin
      n.s1 = d;
      n.s2 = q.s1;
      n.s3 = q.s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else        q <= n;
  end

  assign level = q.s2;
  assign rise  = q.s2 & ~q.s3;

endmodule : lpm_sync

// ==== hdl/lpm_div.sv ====
`timescale 1ns/1ps
`include "lpm_map.svh"

module lpm_div (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [4:0] ratio,
  output logic            tick
);
  import lpm_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic [4:0] cur;
    logic       tick;
  } lpm_div_s;

  lpm_div_s q;
  lpm_div_s n;

  // A new ratio is taken only at the end of a period, so no short pulse appears
  always_comb begin
    n = q;
    if (ce) begin
      n.tick = 1'b0;
    end
    if (ce && run) begin
      if (q.cnt + 5'h01 >= q.cur) begin
        n.cnt  = 5'h00;
        n.tick = 1'b1;
        n.cur  = ratio;
      end else begin
        n.cnt = q.cnt + 5'h01;
      end
    end
  end

  // Out of reset the bus clock runs at one eighth
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '{cnt: 5'h00, cur: `LPM_RATIO_8, tick: 1'b0};
    else        q <= n;
  end

  assign tick = q.tick;

  ratio_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (q.cnt + 5'h01 < q.cur) |=> $stable(q.cur))
    else $error("divider ratio changed inside a period");

endmodule : lpm_div

// ==== sim/lpm_cpu_model.sv ====
`timescale 1ns/1ps

// CPU core side: control writes, wait instruction, accepted interrupts
module lpm_cpu_model (
  input  wire logic clk,
  output logic       we,
  output logic [1:0] divf,
  output logic [5:0] bits,
  output logic       wait_exec,
  output logic       irq
);
  logic [5:0] last_q;

  // Bits are {halt, div8, drive, gate, main stop, source}
  initial begin
    we = 1'b0;
    divf = 2'h0;
    bits = 6'h18;
    wait_exec = 1'b0;
    irq = 1'b0;
    last_q = 6'h18;
  end

  // One write strobe; bits are held with it for the sampling edge
  task automatic wr(input logic [5:0] b, input logic [1:0] f);
    @(posedge clk);
    we <= 1'b1;
    bits <= b;
    divf <= f;
    last_q = b;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  // A gated wait is never issued while the bus runs from the sub clock
  task automatic wait_instr();
    if (last_q[2] && last_q[0]) return;
    @(posedge clk);
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
  endtask : wait_instr

  // Only the enabled waking source reaches here; all others sit at level zero
  task automatic irq_pulse();
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
  endtask : irq_pulse
endmodule : lpm_cpu_model

// ==== sim/lpm_clock_ctrl_tb_top.sv ====
`timescale 1ns/1ps

module lpm_clock_ctrl_tb_top;
  import lpm_pkg::*;
  logic CLK, RSTN, CTRL_WE, WAIT_EXEC, IRQ_ACCEPT, SUB_OSC_INPUT, TIMER_EXT_PULSE;
  logic BUS_EXPANSION_MODE, BYTE_HIGH_ENABLE_N_IN, HOLD_ACKNOWLEDGE_N_IN, ADDR_LATCH_IN;
  logic [19:0] ADDR_IN, ADDR_OUT;
  logic [15:0] DATA_IN, DATA_OUT;
  logic [7:0]  PORT_IN, PORT_OUT;
  logic [3:0]  CHIP_SELECT_LINE_N_IN, STROBE_N_IN, CHIP_SELECT_LINE_N_OUT, STROBE_N_OUT;
  logic [1:0]  divf, CLOCK_OUTPUT_SELECT;
  logic [5:0]  bits;
  lpm_state_e  POWER_STATE;
  logic ALL_CLOCK_HALT_BIT, FORCE_DIV8_SELECT, MAIN_OSC_DRIVE_STRENGTH, DIVIDER_FIELD_LOW;
  logic WAIT_PERIPH_CLOCK_GATE_BIT, DIVIDER_FIELD_HIGH, MAIN_OSC_STOP_BIT, MAIN_OSC_EN;
  logic SYSTEM_CLOCK_SOURCE_SELECT, SUB_OSC_EN, BCLK_EN, WDT_CLK_EN, PERIPH_F1_EN;
  logic PERIPH_F8_EN, PERIPH_F32_EN, SERIAL_AUX_CLOCK_EN, CONVERTER_CLOCK_EN, HANDLER_START;
  logic SUBCLOCK_DIRECT_EN, SUBCLOCK_DIV32_EN, TIMER_COUNT_EXT_EN, SERIAL_EXT_CLK_EN;
  logic BYTE_HIGH_ENABLE_N_OUT, HOLD_ACKNOWLEDGE_N_OUT, ADDR_LATCH_OUT, BUS_CLOCK_OUT;
  logic CLOCK_OUTPUT_PIN;
  wire       CE = 1'b1;
  wire       SERIAL_EXT_SELECT = 1'b1;
  wire       TIMER_EXT_MODE = 1'b1;
  logic [1:0] WR_CLOCK_OUTPUT_SELECT;
  int        errors, check_count, n;

  // Short settle time keeps the stop wake near ten cycles
  lpm_clock_ctrl #(.SETTLE_NS(40)) i_dut (.*, .WR_ALL_CLOCK_HALT_BIT(bits[5]),
    .WR_FORCE_DIV8_SELECT(bits[4]), .WR_MAIN_OSC_DRIVE_STRENGTH(bits[3]),
    .WR_WAIT_PERIPH_CLOCK_GATE_BIT(bits[2]), .WR_DIVIDER_FIELD_LOW(divf[0]),
    .WR_DIVIDER_FIELD_HIGH(divf[1]), .WR_MAIN_OSC_STOP_BIT(bits[1]),
    .WR_SYSTEM_CLOCK_SOURCE_SELECT(bits[0]), .SERIAL_EXT_CLOCK(TIMER_EXT_PULSE));
  lpm_cpu_model i_cpu (.clk(CLK), .we(CTRL_WE), .divf(divf), .bits(bits),
    .wait_exec(WAIT_EXEC), .irq(IRQ_ACCEPT));

  // Clock and a free-running sub oscillator at half the clock rate
  always #2 CLK = ~CLK;
  always @(posedge CLK) SUB_OSC_INPUT <= ~SUB_OSC_INPUT;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // A used-up wait is a mismatch and ends the run
  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask : bound

  task automatic step();
    @(posedge CLK);
    #1;
  endtask : step

  // Cycles from one bus clock tick to the next
  task automatic period(output int p);
    int i;
    for (i = 0; i < 40 && BCLK_EN !== 1'b1; i++) step();
    bound(i, 40);
    step();
    for (p = 1; p < 40 && BCLK_EN !== 1'b1; p++) step();
    bound(p, 40);
  endtask : period

  task automatic pins(input logic [19:0] v);
    @(posedge CLK);
    {ADDR_IN, DATA_IN, PORT_IN} <= {v, v[15:0], v[7:0]};
    {CHIP_SELECT_LINE_N_IN, STROBE_N_IN} <= v[7:0];
    {BYTE_HIGH_ENABLE_N_IN, HOLD_ACKNOWLEDGE_N_IN, ADDR_LATCH_IN} <= v[2:0];
  endtask : pins

  // Interrupt wake; p counts cycles until the handler pulse
  task automatic wake(output int p);
    i_cpu.irq_pulse();
    #1;
    for (p = 0; p < 300 && HANDLER_START !== 1'b1; p++) step();
    bound(p, 300);
    chk(HANDLER_START, 1'b1);
    chk(POWER_STATE, LPM_RUN);
  endtask : wake

  task automatic t_div();
    for (int c = 0; c < 4; c++) begin
      i_cpu.wr(6'h00, 2'(c));
      #1;
      period(n);
      period(n);
      chk(n, (c == 3) ? 16 : (1 << c));
    end
    i_cpu.wr(6'h00, 2'h1);
    $display("divider test done");
  endtask : t_div

  // Wait with and without peripheral gating; ratio two must come back
  task automatic t_wait(input logic gate);
    logic b, f, d;
    {b, f, d} = 3'b000;
    i_cpu.wr({3'b000, gate, 2'b00}, 2'h1);
    i_cpu.wait_instr();
    for (int i = 0; i < 140; i++) begin
      step();
      b |= BCLK_EN | WDT_CLK_EN;
      f |= PERIPH_F1_EN | CONVERTER_CLOCK_EN;
      d |= SUBCLOCK_DIV32_EN;
    end
    chk({POWER_STATE, MAIN_OSC_EN, b}, {LPM_WAIT, 2'b10});
    chk({f, d}, {~gate, 1'b1});
    chk({STROBE_N_OUT, BUS_CLOCK_OUT}, 5'h1F);
    wake(n);
    period(n);
    period(n);
    chk(n, 2);
    $display("wait test done");
  endtask : t_wait

  // Stop from medium speed with the external bus, then interrupt wake
  task automatic t_stop();
    logic b, t;
    {b, t} = 2'b00;
    pins(20'hA5A50);
    step();
    i_cpu.wr(6'h20, 2'h1);
    #1;
    chk({POWER_STATE, FORCE_DIV8_SELECT, MAIN_OSC_DRIVE_STRENGTH}, {LPM_STOP, 2'b11});
    pins(20'h5A5AF);
    i_cpu.wait_instr();
    for (int i = 0; i < 20; i++) begin
      @(posedge CLK);
      TIMER_EXT_PULSE <= i[2];
      #1;
      b |= BCLK_EN | WDT_CLK_EN | PERIPH_F1_EN | CONVERTER_CLOCK_EN | MAIN_OSC_EN;
      b |= SUB_OSC_EN | SUBCLOCK_DIRECT_EN | SUBCLOCK_DIV32_EN | SERIAL_AUX_CLOCK_EN;
      t |= TIMER_COUNT_EXT_EN & SERIAL_EXT_CLK_EN;
    end
    chk({b, t, POWER_STATE}, {2'b01, LPM_STOP});
    chk({ADDR_OUT, PORT_OUT}, 28'hA5A5050);
    chk({STROBE_N_OUT, HOLD_ACKNOWLEDGE_N_OUT, ADDR_LATCH_OUT, BUS_CLOCK_OUT}, 7'h7F);
    wake(n);
    chk({n >= 10, ALL_CLOCK_HALT_BIT}, 2'b10);
    $display("stop test done");
  endtask : t_stop

  // Clock pin changes over 24 cycles in the present state
  task automatic ck_edges(output int t);
    logic l;
    t = 0;
    l = CLOCK_OUTPUT_PIN;
    repeat (24) begin
      step();
      if (CLOCK_OUTPUT_PIN !== l) t++;
      l = CLOCK_OUTPUT_PIN;
    end
  endtask : ck_edges

  // Single-chip clock pin: f8 in wait with and without gating, sub clock select held high in stop,
  // then a hardware reset ends the stop
  task automatic t_clk();
    BUS_EXPANSION_MODE <= 1'b0;
    for (int g = 0; g < 2; g++) begin
      i_cpu.wr({3'b000, g[0], 2'b00}, 2'h1);
      i_cpu.wait_instr();
      step();
      ck_edges(n);
      chk(n, g ? 0 : 3);
      wake(n);
    end
    WR_CLOCK_OUTPUT_SELECT <= 2'h1;
    i_cpu.wr(6'h20, 2'h1);
    step();
    ck_edges(n);
    chk(n, 0);
    chk(CLOCK_OUTPUT_PIN, 1'b1);
    @(posedge CLK);
    RSTN <= 1'b0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    step();
    chk({POWER_STATE, ALL_CLOCK_HALT_BIT, FORCE_DIV8_SELECT}, {LPM_RUN, 2'b01});
    $display("clock pin test done");
  endtask : t_clk

  // Low speed keeps both bits; main stop then forces them
  task automatic t_low();
    i_cpu.wr(6'h00, 2'h1);
    i_cpu.wr(6'h01, 2'h1);
    #1;
    chk({FORCE_DIV8_SELECT, MAIN_OSC_DRIVE_STRENGTH}, 2'b00);
    i_cpu.wr(6'h03, 2'h1);
    #1;
    chk({FORCE_DIV8_SELECT, MAIN_OSC_DRIVE_STRENGTH}, 2'b11);
    period(n);
    period(n);
    chk({n, MAIN_OSC_EN}, {32'd2, 1'b0});
    $display("low power test done");
  endtask : t_low

  initial begin
    {CLK, RSTN, TIMER_EXT_PULSE, SUB_OSC_INPUT, BUS_EXPANSION_MODE} = 5'b00001;
    WR_CLOCK_OUTPUT_SELECT = 2'h2;
    {ADDR_IN, DATA_IN, PORT_IN, CHIP_SELECT_LINE_N_IN, STROBE_N_IN} = '0;
    {BYTE_HIGH_ENABLE_N_IN, HOLD_ACKNOWLEDGE_N_IN, ADDR_LATCH_IN} = 3'b000;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    period(n);
    chk({n, FORCE_DIV8_SELECT, MAIN_OSC_DRIVE_STRENGTH}, {32'd8, 2'b11});
    $display("reset test done");
    t_div();
    t_wait(1'b0);
    t_wait(1'b1);
    t_stop();
    t_clk();
    t_low();
    test_done();
  end
endmodule : lpm_clock_ctrl_tb_top
